// [inc/smb_if.sv]
// Two-wire link between host end and device end
`default_nettype none
interface smb_if;
    // ------------------------------------------------------------
    // Wires
    // ------------------------------------------------------------
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // Open drain: pulled high unless someone drives low
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// [inc/smb_pkg.sv]
// Shared constants for the two-wire configuration link
`default_nettype none
package smb_pkg;
    // ------------------------------------------------------------
    // Addressing and command layout
    // ------------------------------------------------------------
    // Slave address value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h69;
    localparam int CMD_SEL_BIT = 7;
    localparam logic [6:0] OFS_ZERO = 7'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // ------------------------------------------------------------
    // Control byte store
    // ------------------------------------------------------------
    localparam int NUM_BYTES = 8;
    localparam int IDX_W = $clog2(NUM_BYTES);
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] RD_FILL = 8'h00;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 400;
    localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    // ------------------------------------------------------------
    // Host write buffer
    // ------------------------------------------------------------
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
endpackage
`default_nettype wire

// [verif/smb_assertions.sv]
// Link protocol assertions
`default_nettype none
module smb_assertions (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Link wires
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic host_sda_oe_i,
    input wire logic dev_sda_o_i,
    input wire logic dev_sda_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [3:0] pos_r;
    logic [7:0] sh_r;
    logic first_r, rd_r, hit_r, at9, addr_hit;
    assign at9 = pos_r == 4'h8;
    assign addr_hit = sh_r[7:1] == smb_pkg::DEV_ADDR;
    // Repeated start must restart the count
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || ($fell(sda_i) && scl_i)) begin
            pos_r <= 4'h0;
            first_r <= 1'b1;
            rd_r <= 1'b0;
            hit_r <= 1'b0;
        end else if ($rose(scl_i)) begin
            pos_r <= at9 ? 4'h0 : pos_r + 4'h1;
            first_r <= first_r && !at9;
            rd_r <= (first_r && pos_r == 4'h7) ? sda_i : rd_r;
            hit_r <= (first_r && at9) ? addr_hit : hit_r;
            sh_r <= {sh_r[6:0], sda_i};
        end
    end
    sequence s_high; scl_i [*8]; endsequence
    chk_dev_open_drain: assert property (dev_sda_oe_i |-> !dev_sda_o_i) else $error("driven high");
    chk_dev_moves_low: assert property ($changed(dev_sda_oe_i) |-> !scl_i) else $error("moved on high");
    chk_scl_high_min: assert property ($rose(scl_i) |-> s_high) else $error("short high");
    chk_addr_ack: assert property (
        $rose(scl_i) && first_r && at9 && addr_hit |-> dev_sda_oe_i) else $error("no address ack");
    chk_write_ack: assert property (
        $rose(scl_i) && at9 && hit_r && !first_r && !rd_r |-> dev_sda_oe_i) else $error("no ack");
    chk_ack_slot_only: assert property (
        $rose(scl_i) && dev_sda_oe_i && (first_r || !rd_r) |-> at9) else $error("stray drive");
    chk_host_read_ack: assert property (
        $rose(scl_i) && at9 && rd_r && !first_r |-> !dev_sda_oe_i) else $error("drive on host ack");
    chk_no_clash: assert property (scl_i |-> !(dev_sda_oe_i && host_sda_oe_i)) else $error("clash");
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Bench joining host and device ends
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t got %h", $time, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i, rst_i, cmd_valid_i, cmd_ready_o, cmd_read_i, wr_valid_i, wr_ready_o;
    logic rd_valid_o, done_o, nack_o, cfg_wr_o, busy_o;
    logic [7:0] cmd_code_i, cmd_len_i, wr_data_i, rd_data_o;
    logic [smb_pkg::NUM_BYTES-1:0][7:0] cfg_o;
    logic [7:0] q[$];
    int fail_count, checked, pulses;
    smb_if bus ();
    smb_host_end i_smb_host_end (.ref_clk_i, .rst_i, .bus, .cmd_valid_i, .cmd_ready_o, .cmd_read_i, .cmd_code_i,
        .cmd_len_i, .wr_data_i, .wr_valid_i, .wr_ready_o, .rd_data_o, .rd_valid_o, .done_o, .nack_o);
    smb_dev_end i_smb_dev_end (.ref_clk_i, .rst_i, .bus, .cfg_o, .cfg_wr_o, .busy_o);
    smb_assertions i_smb_assertions (.ref_clk_i, .rst_i, .scl_i(bus.scl), .sda_i(bus.sda),
        .host_sda_oe_i(bus.host_sda_oe), .dev_sda_o_i(bus.dev_sda_o), .dev_sda_oe_i(bus.dev_sda_oe));
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    always @(negedge ref_clk_i) if (cfg_wr_o === 1'b1) pulses++;
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        fail_count++;
        end_of_test();
    end
    task automatic push(input logic [7:0] d);
        @(negedge ref_clk_i);
        {wr_data_i, wr_valid_i} = {d, 1'b1};
        while (wr_ready_o !== 1'b1) @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        wr_valid_i = 1'b0;
    endtask
    task automatic run(input logic rd, input logic [7:0] code, input logic [7:0] len);
        @(negedge ref_clk_i);
        {cmd_valid_i, cmd_read_i, cmd_code_i, cmd_len_i} = {1'b1, rd, code, len};
        q = {};
        while (cmd_ready_o !== 1'b1) @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        cmd_valid_i = 1'b0;
        do begin
            @(negedge ref_clk_i);
            if (rd_valid_o === 1'b1) q.push_back(rd_data_o);
        end while (done_o !== 1'b1);
        `CHK(nack_o, 1'b0)
        `CHK(busy_o, 1'b0)
    endtask
    task automatic end_of_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {rst_i, cmd_valid_i, cmd_read_i, wr_valid_i} = 4'h8;
        {cmd_code_i, cmd_len_i, wr_data_i} = 24'h0;
        repeat (10) @(negedge ref_clk_i);
        rst_i = 1'b0;
        for (int k = 0; k < 16; k++) push(8'h10 + 8'(k));
        `CHK(wr_ready_o, 1'b0)
        run(1'b0, 8'h00, 8'h10);
        `CHK(cfg_o, 64'h1716151413121110)
        run(1'b1, 8'h00, 8'h08);
        `CHK(q.size(), 32'h8)
        for (int k = 0; k < 8; k++) `CHK(q[q.size() - 8 + k], 8'h10 + 8'(k))
        pulses = 0;
        // Data arrives late so the host must stretch the clock
        fork
            run(1'b0, 8'h86, 8'h02);
            begin
                repeat (3000) @(negedge ref_clk_i);
                `CHK(busy_o, 1'b1)
                push(8'h5A);
                push(8'hC3);
            end
        join
        `CHK(pulses, 32'h2)
        `CHK(cfg_o, 64'hC35A151413121110)
        run(1'b1, 8'h86, 8'h02);
        `CHK(q.size(), 32'h2)
        `CHK({q[0], q[1]}, 16'h5AC3)
        end_of_test();
    end
endmodule
`default_nettype wire

// [verilog/fifo_buf.sv]
// Flip-flop FIFO with valid/ready on both sides
`default_nettype none
module fifo_buf #(
    parameter int WIDTH = smb_pkg::FIFO_WIDTH,
    parameter int DEPTH = smb_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // Drain side
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    // Depth must be a power of two so pointers wrap naturally
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_r != '0;
    assign out_data_o = mem_r[rp_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= rp_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// [verilog/smb_dev_end.sv]
// Device end of the two-wire configuration link
`default_nettype none
// Contract
// - Serial slave port reaches control bytes
// - Byte, word, block writes and reads
// - Block bytes ascend, stop after any byte
// - Indexed bytes reached via command offset
// - Command bit 7: 0 block, 1 indexed
// - Command bits 6:0 offset, zero for block
// - Start, address, write bit, address acknowledge
// - Block command is all zero, acknowledged
// - Block write data acknowledged, ended by stop
// - Block read returns count then data
// - Host acks reads, nacks last, stops
// - Indexed command top bit one, acknowledged
// - Word write low then high byte
// - Word read low then high, nack high
// - Data pin two-way, clock input only
// - Bits MSB first, bytes ascending
module smb_dev_end (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Two-wire link
    smb_if.dev bus,
    // Control byte store
    output logic [smb_pkg::NUM_BYTES-1:0][7:0] cfg_o,
    output logic cfg_wr_o,
    output logic busy_o
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_CNT,
        ST_WDATA,
        ST_TX,
        ST_SKIP
    } dev_state_e;

    dev_state_e state_r;
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    logic scl_r;
    logic sda_r;
    logic scl_q_r;
    logic sda_q_r;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic active;
    logic byte_end;
    logic wr_en;
    logic [3:0] bitcnt_r;
    logic ack_ph_r;
    logic [7:0] shreg_r;
    logic [6:0] ptr_r;
    logic cnt_pend_r;
    logic [7:0] tx_r;
    logic [7:0] next_tx;
    logic oe_r;
    logic mnack_r;
    logic [smb_pkg::NUM_BYTES-1:0][7:0] cfg_r;
    logic cfg_wr_r;

    function automatic logic in_range(input logic [6:0] p);
        return p < 7'(smb_pkg::NUM_BYTES);
    endfunction

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
        end else begin
            scl_s_r <= {scl_s_r[1:0], bus.scl};
            sda_s_r <= {sda_s_r[1:0], bus.sda};
        end
    end

    // A level counts only once two later stages agree
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            if (scl_s_r[1] == scl_s_r[2]) begin
                scl_r <= scl_s_r[2];
            end
            if (sda_s_r[1] == sda_s_r[2]) begin
                sda_r <= sda_s_r[2];
            end
            scl_q_r <= scl_r;
            sda_q_r <= sda_r;
        end
    end

    assign scl_rise = scl_r && !scl_q_r;
    assign scl_fall = !scl_r && scl_q_r;
    assign start_ev = !sda_r && sda_q_r && scl_r && scl_q_r;
    assign stop_ev = sda_r && !sda_q_r && scl_r && scl_q_r;
    assign active = (state_r != ST_IDLE) && (state_r != ST_SKIP);
    assign byte_end = active && scl_fall && !ack_ph_r && (bitcnt_r == smb_pkg::BYTE_BITS);
    assign wr_en = byte_end && (state_r == ST_WDATA);

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    always_comb begin
        if (cnt_pend_r) begin
            next_tx = 8'(smb_pkg::NUM_BYTES);
        end else if (in_range(ptr_r)) begin
            next_tx = cfg_r[ptr_r[smb_pkg::IDX_W-1:0]];
        end else begin
            next_tx = smb_pkg::RD_FILL;
        end
    end

    // ------------------------------------------------------------
    // Control byte store
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_r <= {smb_pkg::NUM_BYTES{smb_pkg::CFG_RESET}};
            cfg_wr_r <= 1'b0;
        end else begin
            cfg_wr_r <= wr_en && in_range(ptr_r);
            if (wr_en && in_range(ptr_r)) begin
                cfg_r[ptr_r[smb_pkg::IDX_W-1:0]] <= shreg_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            bitcnt_r <= 4'h0;
            ack_ph_r <= 1'b0;
            shreg_r <= 8'h00;
            ptr_r <= smb_pkg::OFS_ZERO;
            cnt_pend_r <= 1'b0;
            tx_r <= 8'h00;
            oe_r <= 1'b0;
            mnack_r <= 1'b0;
        end else if (start_ev) begin
            // Repeated start keeps pointer for the read that follows
            state_r <= ST_ADDR;
            bitcnt_r <= 4'h0;
            ack_ph_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (stop_ev) begin
            state_r <= ST_IDLE;
            ack_ph_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (active && scl_rise) begin
            if (ack_ph_r) begin
                mnack_r <= sda_r;
            end else begin
                shreg_r <= {shreg_r[6:0], sda_r};
                bitcnt_r <= bitcnt_r + 4'h1;
            end
        end else if (active && scl_fall) begin
            if (ack_ph_r) begin
                ack_ph_r <= 1'b0;
                oe_r <= 1'b0;
                if (state_r == ST_TX) begin
                    if (mnack_r) begin
                        state_r <= ST_SKIP;
                    end else begin
                        tx_r <= next_tx;
                        oe_r <= !next_tx[7];
                        cnt_pend_r <= 1'b0;
                        if (!cnt_pend_r) begin
                            ptr_r <= ptr_r + 7'h01;
                        end
                    end
                end
            end else if (bitcnt_r == smb_pkg::BYTE_BITS) begin
                bitcnt_r <= 4'h0;
                ack_ph_r <= 1'b1;
                oe_r <= 1'b1;
                unique case (state_r)
                    ST_ADDR: begin
                        if (shreg_r[7:1] != smb_pkg::DEV_ADDR) begin
                            state_r <= ST_SKIP;
                            ack_ph_r <= 1'b0;
                            oe_r <= 1'b0;
                        end else if (shreg_r[0]) begin
                            state_r <= ST_TX;
                            mnack_r <= 1'b0;
                        end else begin
                            state_r <= ST_CMD;
                        end
                    end
                    ST_CMD: begin
                        if (shreg_r[smb_pkg::CMD_SEL_BIT]) begin
                            ptr_r <= shreg_r[6:0];
                            cnt_pend_r <= 1'b0;
                            state_r <= ST_WDATA;
                        end else begin
                            // Offset bits ignored: block always starts at byte 0
                            ptr_r <= smb_pkg::OFS_ZERO;
                            cnt_pend_r <= 1'b1;
                            state_r <= ST_CNT;
                        end
                    end
                    ST_CNT: begin
                        cnt_pend_r <= 1'b0;
                        state_r <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        ptr_r <= ptr_r + 7'h01;
                    end
                    ST_TX: begin
                        oe_r <= 1'b0;
                    end
                    ST_IDLE, ST_SKIP: begin
                        oe_r <= 1'b0;
                    end
                endcase
            end else if (state_r == ST_TX) begin
                tx_r <= {tx_r[6:0], 1'b0};
                oe_r <= !tx_r[6];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = oe_r;
    assign cfg_o = cfg_r;
    assign cfg_wr_o = cfg_wr_r;
    assign busy_o = active;
endmodule
`default_nettype wire

// [verilog/smb_host_end.sv]
// Host end of the two-wire configuration link
`default_nettype none
module smb_host_end (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Two-wire link
    smb_if.host bus,
    // Command request
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_read_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_len_i,
    // Write data stream
    input wire logic [7:0] wr_data_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    // Read data and status
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic done_o,
    output logic nack_o
);
    typedef enum logic [3:0] {
        H_IDLE, H_START, H_ADDR, H_CMD, H_CNT, H_WDATA,
        H_RSTART, H_RADDR, H_RCNT, H_RDATA, H_STOP
    } host_state_e;

    host_state_e st_r;
    logic [2:0] sda_s_r;
    logic sda_r;
    logic [7:0] qcnt_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [8:0] tx_r;
    logic [8:0] rx_r;
    logic [7:0] rem_r;
    logic [7:0] code_r;
    logic rd_r;
    logic blk_r;
    logic scl_lvl;
    logic sda_lvl;
    logic scl_o_r;
    logic oe_r;
    logic go_wr;
    logic hold;
    logic tick;
    logic sym_end;
    logic f_valid;
    logic [7:0] f_data;
    logic [7:0] rd_data_r;
    logic rd_valid_r;
    logic done_r;
    logic nack_r;

    // ------------------------------------------------------------
    // Write buffer
    // ------------------------------------------------------------
    fifo_buf #(.WIDTH(smb_pkg::FIFO_WIDTH), .DEPTH(smb_pkg::FIFO_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .in_data_i(wr_data_i),
        .in_valid_i(wr_valid_i),
        .in_ready_o(wr_ready_o),
        .out_data_o(f_data),
        .out_valid_o(f_valid),
        .out_ready_i(sym_end && go_wr)
    );

    // ------------------------------------------------------------
    // Data pin sampling
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sda_s_r <= 3'h7;
            sda_r <= 1'b1;
        end else begin
            sda_s_r <= {sda_s_r[1:0], bus.sda};
            if (sda_s_r[1] == sda_s_r[2]) begin
                sda_r <= sda_s_r[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Line levels per quarter bit
    // ------------------------------------------------------------
    always_comb begin
        scl_lvl = 1'b1;
        sda_lvl = 1'b1;
        unique case (st_r)
            H_IDLE: begin
                scl_lvl = 1'b1;
            end
            H_START, H_RSTART: begin
                scl_lvl = (q_r == 2'h1) || (q_r == 2'h2);
                sda_lvl = q_r < 2'h2;
            end
            H_STOP: begin
                scl_lvl = q_r != 2'h0;
                sda_lvl = q_r >= 2'h2;
            end
            H_ADDR, H_CMD, H_CNT, H_WDATA, H_RADDR, H_RCNT, H_RDATA: begin
                scl_lvl = (q_r == 2'h1) || (q_r == 2'h2);
                sda_lvl = tx_r[8];
            end
        endcase
    end

    // Clock stretches low while a write byte is due and the buffer has none ready
    assign go_wr = (bit_r == smb_pkg::BYTE_BITS) &&
        ((st_r == H_CMD && !rd_r && !blk_r && rem_r != 8'h00) ||
         (st_r == H_CNT && rem_r != 8'h00) ||
         (st_r == H_WDATA && rem_r > 8'h01));
    assign hold = (q_r == 2'h3) && go_wr && !f_valid;
    assign tick = (qcnt_r == 8'(smb_pkg::QTR_CYC - 1)) && !hold;
    assign sym_end = tick && (q_r == 2'h3);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        rd_valid_r <= 1'b0;
        done_r <= 1'b0;
        if (rst_i) begin
            st_r <= H_IDLE;
            qcnt_r <= 8'h00;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            tx_r <= 9'h1FF;
            rx_r <= 9'h000;
            rem_r <= 8'h00;
            code_r <= 8'h00;
            rd_r <= 1'b0;
            blk_r <= 1'b0;
            rd_data_r <= 8'h00;
            nack_r <= 1'b0;
        end else if (st_r == H_IDLE) begin
            if (cmd_valid_i) begin
                st_r <= H_START;
                rd_r <= cmd_read_i;
                code_r <= cmd_code_i;
                blk_r <= !cmd_code_i[smb_pkg::CMD_SEL_BIT];
                rem_r <= cmd_len_i;
                nack_r <= 1'b0;
                qcnt_r <= 8'h00;
                q_r <= 2'h0;
                bit_r <= 4'h0;
            end
        end else begin
            if (!hold) begin
                qcnt_r <= tick ? 8'h00 : qcnt_r + 8'h01;
            end
            if (tick) begin
                q_r <= q_r + 2'h1;
            end
            if (tick && q_r == 2'h1) begin
                rx_r <= {rx_r[7:0], sda_r};
            end
            if (sym_end) begin
                if (st_r != H_START && st_r != H_RSTART && st_r != H_STOP &&
                    bit_r != smb_pkg::BYTE_BITS) begin
                    bit_r <= bit_r + 4'h1;
                    tx_r <= {tx_r[7:0], 1'b1};
                end else begin
                    bit_r <= 4'h0;
                    unique case (st_r)
                        H_IDLE: begin
                            st_r <= H_IDLE;
                        end
                        H_START: begin
                            st_r <= H_ADDR;
                            tx_r <= {smb_pkg::DEV_ADDR, 1'b0, 1'b1};
                        end
                        H_RSTART: begin
                            st_r <= H_RADDR;
                            tx_r <= {smb_pkg::DEV_ADDR, 1'b1, 1'b1};
                        end
                        H_ADDR, H_RADDR: begin
                            if (rx_r[0]) begin
                                nack_r <= 1'b1;
                                st_r <= H_STOP;
                            end else if (st_r == H_ADDR) begin
                                st_r <= H_CMD;
                                tx_r <= {code_r, 1'b1};
                            end else if (blk_r) begin
                                st_r <= H_RCNT;
                                tx_r <= {8'hFF, 1'b0};
                            end else begin
                                st_r <= H_RDATA;
                                tx_r <= {8'hFF, rem_r <= 8'h01};
                            end
                        end
                        H_CMD, H_CNT: begin
                            if (st_r == H_CMD && rd_r) begin
                                st_r <= H_RSTART;
                            end else if (st_r == H_CMD && blk_r) begin
                                st_r <= H_CNT;
                                tx_r <= {rem_r, 1'b1};
                            end else if (go_wr) begin
                                st_r <= H_WDATA;
                                tx_r <= {f_data, 1'b1};
                            end else begin
                                st_r <= H_STOP;
                            end
                        end
                        H_WDATA: begin
                            rem_r <= rem_r - 8'h01;
                            if (go_wr) begin
                                tx_r <= {f_data, 1'b1};
                            end else begin
                                st_r <= H_STOP;
                            end
                        end
                        H_RCNT: begin
                            // A zero count still reads one byte to end cleanly
                            rem_r <= (rx_r[8:1] == 8'h00) ? 8'h01 : rx_r[8:1];
                            st_r <= H_RDATA;
                            tx_r <= {8'hFF, rx_r[8:1] <= 8'h01};
                        end
                        H_RDATA: begin
                            rd_data_r <= rx_r[8:1];
                            rd_valid_r <= 1'b1;
                            rem_r <= rem_r - 8'h01;
                            if (rem_r > 8'h01) begin
                                tx_r <= {8'hFF, rem_r == 8'h02};
                            end else begin
                                st_r <= H_STOP;
                            end
                        end
                        H_STOP: begin
                            st_r <= H_IDLE;
                            done_r <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_o_r <= 1'b1;
            oe_r <= 1'b0;
        end else begin
            scl_o_r <= scl_lvl;
            oe_r <= !sda_lvl;
        end
    end

    assign bus.scl = scl_o_r;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = oe_r;
    assign cmd_ready_o = st_r == H_IDLE;
    assign rd_data_o = rd_data_r;
    assign rd_valid_o = rd_valid_r;
    assign done_o = done_r;
    assign nack_o = nack_r;
endmodule
`default_nettype wire
